/* File: shared/trig_sel_pkg.sv */
// Constants and types shared by the trigger selection logic
package trig_sel_pkg;

  // ----------------------------------------------------------------
  // Register map (printed offsets; not all multiples of four)
  // ----------------------------------------------------------------
  localparam logic [15:0] BOARD_COMMAND_IDX = 16'h0000;
  localparam logic [15:0] TRIGGER_SOURCE_SELECT_IDX = 16'h9C40;
  localparam logic [15:0] TRIGGER_CONNECTOR_DIRECTION_IDX = 16'h9CA4;
  localparam logic [15:0] TRIGGER_INPUT_TERMINATION_IDX = 16'h9CAE;

  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] FREE_RUN_START = 32'h0000_0000;
  localparam logic [31:0] RISING_EDGE_SELECT = 32'h0000_4E20;
  localparam logic [31:0] FALLING_EDGE_SELECT = 32'h0000_4E2A;
  localparam logic [31:0] ANY_EDGE_SELECT = 32'h0000_4E3E;
  localparam logic [31:0] FORCED_EVENT_CMD = 32'h0000_0010;
  localparam logic [31:0] TRIGGER_SOURCE_SELECT_RESET = 32'h0000_0000;
  localparam logic [31:0] TRIGGER_CONNECTOR_DIRECTION_RESET = 32'h0000_0000;
  localparam logic [31:0] TRIGGER_INPUT_TERMINATION_RESET = 32'h0000_0000;
  localparam logic [31:0] BOARD_COMMAND_RESET = 32'h0000_0000;

  // Setup delay between start and free-run trigger
  localparam int SETUP_TIME_NS = 100;
  localparam int CLK_PERIOD_NS = 25;
  localparam logic [7:0] SETUP_CYCLES = 8'((SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_ARMED = 2'b10,
    ST_RUN = 2'b11
  } arm_state_type;

endpackage : trig_sel_pkg

/* File: rtl/trig_input_sync.sv */
// Two-stage synchroniser and edge detector for the external trigger input
`timescale 1ns/1ps
module trig_input_sync (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Pin level
  input wire logic level_in,
  // Edge pulses
  output logic rise_out,
  output logic fall_out
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // Chain; the first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= level_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // One cycle wide per edge
  assign rise_out = sync_reg & ~prev_reg;
  assign fall_out = ~sync_reg & prev_reg;

endmodule : trig_input_sync

/* File: rtl/setup_timer.sv */
// Countdown timer for the setup delay after start
`timescale 1ns/1ps
module setup_timer
  import trig_sel_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Control
  input wire logic load_in,
  // Status
  output logic done_out
);

  logic [7:0] count_reg;
  logic [7:0] count_next;

  // Reload on start, then count down to zero; done flags the count of one
  assign count_next = load_in ? SETUP_CYCLES :
                      (count_reg != 8'h00) ? count_reg - 8'h01 : 8'h00;
  assign done_out = (count_reg == 8'h01);

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      count_reg <= 8'h00;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule : setup_timer

/* File: rtl/replay_trigger_select.sv */
// Trigger source selection, arming and connector control for replay
`timescale 1ns/1ps
//
// Behaviour
// - Free-run mode triggers after start once the setup delay expires, no event needed.
// - Force command triggers once, only while armed and waiting; ignored otherwise.
// - Internal mode with direction zero leaves the connector driver disabled.
// - Internal mode with direction one drives a high trigger pulse at replay start.
// - Any external mode makes the connector an input, ignoring the direction setting.
// - Rising edge code triggers on rising external edges.
// - Falling edge code triggers on falling external edges.
// - Any edge code triggers on both external edges.
// - External mode triggers on first qualifying edge once armed after the setup delay; earlier edges ignored.
// - After a trigger, edges are ignored until replay ends and board is re-armed.
// - Termination on only when setting set and connector is an external input.
module replay_trigger_select
  import trig_sel_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Register port
  input wire logic [15:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  output logic [31:0] reg_rdata_out,
  // Replay engine
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic replay_done_in,
  output logic trigger_out,
  output logic armed_out,
  output logic running_out,
  // Trigger connector
  input wire logic trig_pin_in,
  output logic trig_pin_out,
  output logic trig_pin_oe_n_out,
  output logic term_enable_out
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] mode_reg;
  logic [31:0] dir_reg;
  logic [31:0] term_reg;
  logic [31:0] cmd_reg;
  arm_state_type state_reg;
  arm_state_type state_next;
  logic trig_out_reg;
  logic pin_out_reg;

  // Address decode
  wire sel_cmd = (reg_addr_in == BOARD_COMMAND_IDX);
  wire sel_mode = (reg_addr_in == TRIGGER_SOURCE_SELECT_IDX);
  wire sel_dir = (reg_addr_in == TRIGGER_CONNECTOR_DIRECTION_IDX);
  wire sel_term = (reg_addr_in == TRIGGER_INPUT_TERMINATION_IDX);

  // Mode decode
  wire mode_rise = (mode_reg == RISING_EDGE_SELECT);
  wire mode_fall = (mode_reg == FALLING_EDGE_SELECT);
  wire mode_both = (mode_reg == ANY_EDGE_SELECT);
  wire mode_ext = mode_rise | mode_fall | mode_both;
  wire mode_soft = ~mode_ext;

  // Register write and readback; the command register reads back last code
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      mode_reg <= TRIGGER_SOURCE_SELECT_RESET;
      dir_reg <= TRIGGER_CONNECTOR_DIRECTION_RESET;
      term_reg <= TRIGGER_INPUT_TERMINATION_RESET;
      cmd_reg <= BOARD_COMMAND_RESET;
    end else if (reg_write_in) begin
      if (sel_mode) begin
        mode_reg <= reg_wdata_in;
      end else if (sel_dir) begin
        dir_reg <= reg_wdata_in;
      end else if (sel_term) begin
        term_reg <= reg_wdata_in;
      end else if (sel_cmd) begin
        cmd_reg <= reg_wdata_in;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  assign reg_rdata_out = sel_mode ? mode_reg :
                         sel_dir ? dir_reg :
                         sel_term ? term_reg :
                         sel_cmd ? cmd_reg : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Trigger sources
  // ----------------------------------------------------------------
  logic edge_rise;
  logic edge_fall;
  logic setup_done;

  trig_input_sync u_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .level_in(trig_pin_in),
    .rise_out(edge_rise),
    .fall_out(edge_fall)
  );

  // Timer reloads on start so free-run waits only for setup
  wire start_ok = start_in & (state_reg == ST_IDLE);
  setup_timer u_timer (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .load_in(start_ok),
    .done_out(setup_done)
  );

  // Qualified external edge per selected polarity
  wire ext_edge = (mode_rise & edge_rise)
                | (mode_fall & edge_fall)
                | (mode_both & (edge_rise | edge_fall));

  // Force is a write of the force code in any state; trig_hit gates it with armed
  wire force_cmd = reg_write_in & sel_cmd & (reg_wdata_in == FORCED_EVENT_CMD);

  // Edges count only in the armed state, so earlier ones are lost
  wire armed = (state_reg == ST_ARMED);
  wire trig_hit = armed & ((mode_ext & ext_edge) | force_cmd);

  // ----------------------------------------------------------------
  // Arming state machine
  // ----------------------------------------------------------------
  // Free run enters RUN straight from setup; stop aborts anywhere
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_in) begin
          state_next = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (setup_done) begin
          state_next = mode_soft ? ST_RUN : ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (trig_hit) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (replay_done_in) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (stop_in) begin
      state_next = ST_IDLE;
    end
  end

  // Trigger pulse for one cycle whenever replay is entered
  wire trig_now = (state_next == ST_RUN) & (state_reg != ST_RUN);

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_reg <= ST_IDLE;
      trig_out_reg <= 1'b0;
      pin_out_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      trig_out_reg <= trig_now;
      pin_out_reg <= trig_now & mode_soft & dir_reg[0];
    end
  end

  assign trigger_out = trig_out_reg;
  assign armed_out = armed;
  assign running_out = (state_reg == ST_RUN);

  // ----------------------------------------------------------------
  // Connector control
  // ----------------------------------------------------------------
  // Driver enabled only in internal mode with direction one; active low enable
  wire drive_pin = mode_soft & dir_reg[0];
  assign trig_pin_oe_n_out = ~drive_pin;
  assign trig_pin_out = pin_out_reg;
  // Termination only when acting as an external input
  assign term_enable_out = mode_ext & term_reg[0];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_force_ignored: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (force_cmd && state_reg == ST_IDLE && !start_in) |=> (state_reg == ST_IDLE && !trigger_out))
    else $error("force accepted while not armed");

  a_force_fires: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (force_cmd && armed && !stop_in) |=> trigger_out && running_out)
    else $error("force while armed did not trigger");

  a_free_run_start: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state_reg == ST_SETUP && setup_done && mode_soft && !stop_in) |=> running_out)
    else $error("free run did not start after setup");

  a_pin_disabled: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (mode_soft && !dir_reg[0]) |-> trig_pin_oe_n_out)
    else $error("driver on with direction zero");

  a_pin_pulse: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (trig_now && mode_soft && dir_reg[0]) |=> trig_pin_out && trigger_out)
    else $error("no output pulse at replay start");

  a_ext_input: assert property (@(posedge clk_in) disable iff (!resetn_in)
    mode_ext |-> (trig_pin_oe_n_out && !trig_pin_out) || $past(mode_soft))
    else $error("connector driven in external mode");

  a_rise_edge: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (armed && mode_rise && edge_rise && !stop_in) |=> trigger_out)
    else $error("rising edge missed");

  a_fall_edge: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (armed && mode_fall && edge_fall && !stop_in) |=> trigger_out)
    else $error("falling edge missed");

  a_both_edge: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (armed && mode_both && (edge_rise || edge_fall) && !stop_in) |=> trigger_out)
    else $error("edge missed in any edge mode");

  a_no_retrigger: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (running_out && !replay_done_in && !stop_in) |=> !trigger_out && running_out)
    else $error("retrigger during replay");

  a_early_edge: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state_reg == ST_SETUP && mode_ext) |=> !trigger_out)
    else $error("edge before arming triggered");

  a_termination: assert property (@(posedge clk_in) disable iff (!resetn_in)
    term_enable_out |-> (mode_ext && trig_pin_oe_n_out))
    else $error("termination on while not an input");

  a_edge_pulse: assert property (@(posedge clk_in) disable iff (!resetn_in)
    edge_rise |=> !edge_rise)
    else $error("edge pulse wider than one cycle");

  // ----------------------------------------------------------------
  // Output shape and state checks
  // ----------------------------------------------------------------
  a_fall_pulse: assert property (@(posedge clk_in) disable iff (!resetn_in)
    edge_fall |=> !edge_fall)
    else $error("fall pulse wider than one cycle");

  a_edge_exclusive: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !(edge_rise && edge_fall))
    else $error("rise and fall pulses together");

  a_trig_one_cycle: assert property (@(posedge clk_in) disable iff (!resetn_in)
    trigger_out |=> !trigger_out)
    else $error("trigger pulse wider than one cycle");

  a_trig_in_run: assert property (@(posedge clk_in) disable iff (!resetn_in)
    trigger_out |-> running_out)
    else $error("trigger without replay");

  a_pin_follows: assert property (@(posedge clk_in) disable iff (!resetn_in)
    trig_pin_out |-> trigger_out)
    else $error("connector pulse without trigger");

  a_ext_no_pulse: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (mode_ext && $past(mode_ext)) |-> !trig_pin_out)
    else $error("connector pulsed in external mode");

  a_drive_on: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (mode_soft && dir_reg[0]) |-> !trig_pin_oe_n_out)
    else $error("driver off with direction one");

  a_armed_ext: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state_reg == ST_SETUP && setup_done && mode_ext && !stop_in) |=> armed_out)
    else $error("not armed after setup");

  a_stay_armed: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (armed && !trig_hit && !stop_in) |=> armed_out)
    else $error("armed state left without trigger");

  a_term_on: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (mode_ext && term_reg[0]) |-> term_enable_out)
    else $error("termination off while requested");

  a_term_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!mode_ext || !term_reg[0]) |-> !term_enable_out)
    else $error("termination on while not requested");

  a_force_busy: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (force_cmd && running_out) |=> !trigger_out)
    else $error("force accepted during replay");

  a_replay_end: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (running_out && replay_done_in) |=> (!running_out && !trigger_out))
    else $error("replay did not end");

  a_idle_quiet: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state_reg == ST_IDLE) |=> !trigger_out)
    else $error("trigger from idle");

  a_setup_wait: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state_reg == ST_SETUP && !setup_done) |=> !running_out)
    else $error("replay before setup expired");

endmodule : replay_trigger_select

/* File: sim/trig_source_model.sv */
// Behavioural external trigger source sharing the connector with the board
`timescale 1ns/1ps
module trig_source_model (
  // Connector as seen from outside
  input wire logic oe_n_in,
  input wire logic drv_in,
  output logic pin_out
);
  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  logic src_level = 1'b0;

  // Board owns the wire while its enable is low, else the source does
  assign pin_out = oe_n_in ? src_level : drv_in;

  // Caller moves the level just after a clock edge, never on it
  task set_level(input logic v);
    src_level = v;
  endtask : set_level
endmodule : trig_source_model

/* File: sim/replay_trigger_select_tb_top.sv */
// Self-checking bench for the replay trigger selection block
`timescale 1ns/1ps
module replay_trigger_select_tb_top;
  import trig_sel_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [15:0] reg_addr_in = 16'h0000;
  logic [31:0] reg_wdata_in = 32'h0000_0000;
  logic reg_write_in = 1'b0;
  logic start_in = 1'b0;
  logic stop_in = 1'b0;
  logic replay_done_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic trigger_out, armed_out, running_out, trig_pin_in;
  logic trig_pin_out, trig_pin_oe_n_out, term_enable_out;
  int fail_count = 0;
  int comparisons = 0;
  int n;
  logic [31:0] modes [3] = '{RISING_EDGE_SELECT, FALLING_EDGE_SELECT, ANY_EDGE_SELECT};
  logic pre [3] = '{1'b1, 1'b0, 1'b0};

  // ----------------------------------------------------------------
  // Clock, design and far side
  // ----------------------------------------------------------------
  always #12.5 clk_in = ~clk_in;

  replay_trigger_select i_dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
    .reg_rdata_out(reg_rdata_out), .start_in(start_in), .stop_in(stop_in),
    .replay_done_in(replay_done_in), .trigger_out(trigger_out), .armed_out(armed_out),
    .running_out(running_out), .trig_pin_in(trig_pin_in), .trig_pin_out(trig_pin_out),
    .trig_pin_oe_n_out(trig_pin_oe_n_out), .term_enable_out(term_enable_out));

  trig_source_model i_src (.oe_n_in(trig_pin_oe_n_out), .drv_in(trig_pin_out),
    .pin_out(trig_pin_in));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Inputs move 2 ns after the edge, or 3 ns when they follow rd, clear of sampling
  task tick(input int k);
    repeat (k) @(posedge clk_in);
    #2;
  endtask : tick

  task wr(input logic [15:0] a, input logic [31:0] d);
    tick(1);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_write_in = 1'b1;
    tick(1);
    reg_write_in = 1'b0;
  endtask : wr

  task rd(input logic [15:0] a, input logic [31:0] exp, input string what);
    tick(1);
    reg_addr_in = a;
    #1;
    check(what, reg_rdata_out, exp);
  endtask : rd

  task start_board();
    tick(1);
    start_in = 1'b1;
    tick(1);
    start_in = 1'b0;
  endtask : start_board

  task finish_replay();
    tick(1);
    replay_done_in = 1'b1;
    tick(1);
    replay_done_in = 1'b0;
  endtask : finish_replay

  // Bounded wait; 12 means no trigger seen
  task wait_trig(output int k);
    k = 0;
    while (trigger_out !== 1'b1 && k < 12) begin
      tick(1);
      k++;
    end
  endtask : wait_trig

  task end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk_in);
    fail_count++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    tick(8);
    resetn_in = 1'b1;
    rd(TRIGGER_SOURCE_SELECT_IDX, TRIGGER_SOURCE_SELECT_RESET, "mode");
    rd(TRIGGER_CONNECTOR_DIRECTION_IDX, TRIGGER_CONNECTOR_DIRECTION_RESET, "dir");
    rd(TRIGGER_INPUT_TERMINATION_IDX, TRIGGER_INPUT_TERMINATION_RESET, "term");
    wr(16'h0004, 32'hFFFF_FFFF);
    rd(16'h0004, 32'h0000_0000, "unmapped");
    // Force while idle must do nothing
    wr(BOARD_COMMAND_IDX, FORCED_EVENT_CMD);
    wait_trig(n);
    check("idle force", 32'(n), 32'd12);
    rd(BOARD_COMMAND_IDX, FORCED_EVENT_CMD, "cmd");
    $display("test registers done");
    // Free run with the connector unused, then driven
    for (int d = 0; d < 2; d++) begin
      wr(TRIGGER_CONNECTOR_DIRECTION_IDX, 32'(d));
      wr(TRIGGER_INPUT_TERMINATION_IDX, 32'h0000_0001);
      check("term", term_enable_out, 32'h0);
      start_board();
      wait_trig(n);
      // Start edge loads the timer; trigger register follows the last count
      check("setup", 32'(n), 32'(SETUP_CYCLES));
      check("oe_n", trig_pin_oe_n_out, 32'(d == 0));
      check("wire", trig_pin_in, 32'(d));
      check("running", running_out, 32'h1);
      tick(1);
      check("pulse", trigger_out, 32'h0);
      finish_replay();
      check("stopped", running_out, 32'h0);
      $display("test free run dir %0d done", d);
    end
    // Edge modes: early edge, wrong edge (rise and fall modes only), good edge, busy edges
    for (int m = 0; m < 3; m++) begin
      wr(TRIGGER_SOURCE_SELECT_IDX, modes[m]);
      rd(TRIGGER_SOURCE_SELECT_IDX, modes[m], "mode");
      check("term", term_enable_out, 32'h1);
      check("oe_n", trig_pin_oe_n_out, 32'h1);
      i_src.set_level(~pre[m]);
      tick(6);
      i_src.set_level(pre[m]);
      tick(6);
      start_board();
      wait_trig(n);
      check("early", 32'(n), 32'd12);
      check("armed", armed_out, 32'h1);
      i_src.set_level(~pre[m]);
      wait_trig(n);
      if (m < 2) begin
        check("wrong edge", 32'(n), 32'd12);
        i_src.set_level(pre[m]);
        wait_trig(n);
      end
      // Two synchroniser stages, then the trigger register
      check("edge", 32'(n), 32'd3);
      tick(1);
      check("pulse", trigger_out, 32'h0);
      i_src.set_level(~trig_pin_in);
      wr(BOARD_COMMAND_IDX, FORCED_EVENT_CMD);
      i_src.set_level(~trig_pin_in);
      wait_trig(n);
      check("busy", 32'(n), 32'd12);
      check("running", running_out, 32'h1);
      finish_replay();
      $display("test edge mode %0d done", m);
    end
    // Force while armed, then abort
    start_board();
    tick(6);
    check("armed", armed_out, 32'h1);
    wr(BOARD_COMMAND_IDX, FORCED_EVENT_CMD);
    wait_trig(n);
    // Trigger register is set at the very edge that takes the write
    check("force", 32'(n), 32'd0);
    tick(1);
    stop_in = 1'b1;
    tick(1);
    stop_in = 1'b0;
    check("abort", running_out, 32'h0);
    $display("test force done");
    end_of_test();
  end
endmodule : replay_trigger_select_tb_top
